// ### hw/blw_pkg.sv
// shared constants and types for the local-master write sequencer
package blw_pkg;

    // widths
    localparam int BLW_ADDR_W = 32;
    localparam int BLW_DATA_W = 32;
    localparam int BLW_BE_W   = 4;
    localparam int BLW_LEN_W  = 8;

    // local status field codes
    localparam logic [3:0] BLW_STATUS_IDLE      = 4'h0;
    localparam logic [3:0] BLW_STATUS_ADDR_LOAD = 4'h1;
    localparam logic [3:0] BLW_STATUS_BUS_XACT  = 4'h2;
    localparam logic [3:0] BLW_STATUS_BUS_TERM  = 4'h3;

    // ending kind codes
    localparam logic [1:0] BLW_END_NONE   = 2'h0;
    localparam logic [1:0] BLW_END_NORMAL = 2'h1;

    // local address counter step per word
    localparam logic [31:0] BLW_ADDR_STEP = 32'h4;

    // core sequencer states
    typedef enum logic [2:0] {
        CS_IDLE,
        CS_REQ,
        CS_GNT,
        CS_LOAD,
        CS_ADDR,
        CS_WAIT1,
        CS_DATA,
        CS_TURN
    } blw_core_e;

    // local master states
    typedef enum logic [1:0] {
        HS_IDLE,
        HS_REQ,
        HS_RUN
    } blw_host_e;

endpackage

// ### hw/blw_local_if.sv
// local interface between the write sequencer and the local master
`timescale 1ns/1ps
`default_nettype none
interface blw_local_if
    import blw_pkg::*;
#(
    parameter int LEN_W = BLW_LEN_W
);
    logic                  localRequest32N;
    logic [BLW_DATA_W-1:0] localAddrDataIn;
    logic [BLW_BE_W-1:0]   localCmdByteEnIn;
    logic [LEN_W-1:0]      localBurstLenIn;
    logic                  localReadyN;
    logic                  localGrantN;
    logic [3:0]            localMasterState;
    logic                  localDataTransferStrobeN;
    logic [LEN_W-1:0]      remainingBeatsCount;
    logic [1:0]            endingKind;

    modport core (
        input  localRequest32N,
        input  localAddrDataIn,
        input  localCmdByteEnIn,
        input  localBurstLenIn,
        input  localReadyN,
        output localGrantN,
        output localMasterState,
        output localDataTransferStrobeN,
        output remainingBeatsCount,
        output endingKind
    );

    modport master (
        output localRequest32N,
        output localAddrDataIn,
        output localCmdByteEnIn,
        output localBurstLenIn,
        output localReadyN,
        input  localGrantN,
        input  localMasterState,
        input  localDataTransferStrobeN,
        input  remainingBeatsCount,
        input  endingKind
    );
endinterface
`default_nettype wire

// ### hw/blw_word_slot.sv
// one-word holding slot with load and clear
`timescale 1ns/1ps
`default_nettype none
module blw_word_slot
    import blw_pkg::*;
#(
    parameter int W = BLW_DATA_W + BLW_BE_W
)(
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    // control
    input  wire logic         load,
    input  wire logic         clear,
    input  wire logic [W-1:0] din,
    // state
    output logic              valid,
    output logic [W-1:0]      dout
);
    typedef struct packed {
        logic         full;
        logic [W-1:0] data;
    } blw_slot_s;

    blw_slot_s r;
    blw_slot_s n;

    always_comb
    begin
        n = r;
        if (load)
        begin
            n.full = 1'b1;
            n.data = din;
        end
        else if (clear)
        begin
            n.full = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign valid = r.full;
    assign dout  = r.data;
endmodule
`default_nettype wire

// ### hw/blw_core.sv
// bus-master write sequencer: local interface to parallel bus
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: local master requests with address, command, length
// R2: assert reqn cycle after local request
// R3: grant locally when gntn and bus idle
// R4: address-loading status while latching request fields
// R5: local master drops request after address loading
// R6: framen, address, command, bus-transaction status
// R7: burst count loaded in address phase
// R8: strobe word cycle after local ready
// R9: local ready only when data available
// R10: drop reqn after framen with request gone
// R11: first data word driven after address phase
// R12: buffer one word ahead of pending phase
// R13: local grant follows gntn deassertion
// R14: hold bus data until irdyn and trdyn
// R15: no strobe after local ready deasserted
// R16: irdyn only when data word held
// R17: target asserts devseln and trdyn, keeps them
// R18: burst count decrements per completed phase
// R19: irdyn deasserted without next word
// R20: final phase: irdyn asserted, framen deasserted
// R21: release bus, termination status, normal ending
// R22: local handshakes active low, rising edge
module blw_core
    import blw_pkg::*;
#(
    parameter int LEN_W = BLW_LEN_W
)(
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    // local side
    blw_local_if.core                  lm,
    // arbitration
    output logic                       reqn,
    input  wire logic                  gntn,
    // bus control inputs
    input  wire logic                  framenIn,
    input  wire logic                  irdynIn,
    input  wire logic                  trdyn,
    // bus drive
    output logic                       framenOut,
    output logic                       framenOe,
    output logic                       irdynOut,
    output logic                       irdynOe,
    output logic [BLW_DATA_W-1:0]      adOut,
    output logic [BLW_BE_W-1:0]        cbenOut,
    output logic                       adCbenOe
);
    localparam int WW = BLW_DATA_W + BLW_BE_W;

    typedef struct packed {
        blw_core_e             st;
        logic                  reqN;
        logic                  grantN;
        logic [3:0]            status;
        logic [1:0]            ending;
        logic                  frameN;
        logic                  frameOe;
        logic                  irdyN;
        logic                  irdyOe;
        logic                  busOe;
        logic [BLW_DATA_W-1:0] ad;
        logic [BLW_BE_W-1:0]   cben;
        logic [BLW_DATA_W-1:0] addr;
        logic [BLW_BE_W-1:0]   cmd;
        logic [LEN_W-1:0]      len;
        logic [LEN_W-1:0]      remain;
        logic [LEN_W-1:0]      taken;
        logic                  xferN;
    } blw_core_s;

    blw_core_s r;
    blw_core_s n;

    logic          busIdle, take, done, curValid, aheadValid, curLoad, curClear;
    logic          aheadLoad, aheadClear, curNextV, aheadNextV;
    logic [WW-1:0] incoming, curData, aheadData, curDin, curNextD;

    // word on the bus and the word buffered behind it
    blw_word_slot #(.W(WW)) curSlot (.sys_clk(sys_clk), .resetn(resetn), .load(curLoad),
        .clear(curClear), .din(curDin), .valid(curValid), .dout(curData));

    blw_word_slot #(.W(WW)) aheadSlot (.sys_clk(sys_clk), .resetn(resetn), .load(aheadLoad),
        .clear(aheadClear), .din(incoming), .valid(aheadValid), .dout(aheadData));

    always_comb
    begin
        n          = r;
        busIdle    = framenIn & irdynIn;
        take       = !r.xferN;
        incoming   = {lm.localAddrDataIn, lm.localCmdByteEnIn};
        done       = (r.st == CS_DATA) && !r.irdyN && !trdyn; // R14
        curLoad    = 1'b0;
        curClear   = 1'b0;
        curDin     = incoming;
        aheadLoad  = 1'b0;
        aheadClear = 1'b0;
        // slot steering
        if (done && aheadValid)
        begin
            curLoad    = 1'b1;
            curDin     = aheadData;
            aheadClear = !take;
            aheadLoad  = take;
        end
        else if ((!curValid || done) && take)
            curLoad = 1'b1;
        else if (done)
            curClear = 1'b1;
        else if (take)
            aheadLoad = 1'b1; // R12
        curNextV   = curLoad || (curValid && !curClear);
        aheadNextV = aheadLoad || (aheadValid && !aheadClear);
        curNextD   = curLoad ? curDin : curData;
        if (take)
            n.taken = r.taken + 1'b1;
        if (gntn)
            n.grantN = 1'b1; // R13
        case (r.st)
            CS_IDLE:
            begin
                n.status = BLW_STATUS_IDLE;
                n.irdyOe = 1'b0;
                if (!lm.localRequest32N) // R22
                begin
                    n.reqN = 1'b0; // R2
                    n.st   = CS_REQ;
                end
            end
            CS_REQ:
            begin
                if (lm.localRequest32N)
                begin
                    n.reqN = 1'b1;
                    n.st   = CS_IDLE;
                end
                else if (!gntn && busIdle)
                begin
                    n.grantN = 1'b0; // R3
                    n.st     = CS_GNT;
                end
            end
            CS_GNT:
            begin
                if (!lm.localRequest32N && !gntn)
                begin
                    n.status = BLW_STATUS_ADDR_LOAD; // R4
                    n.addr   = lm.localAddrDataIn;
                    n.cmd    = lm.localCmdByteEnIn;
                    n.len    = lm.localBurstLenIn;
                    n.taken  = '0;
                    n.ending = BLW_END_NONE;
                    n.st     = CS_LOAD;
                end
                else if (lm.localRequest32N)
                begin
                    n.reqN   = 1'b1;
                    n.grantN = 1'b1;
                    n.st     = CS_IDLE;
                end
                else
                    n.st = CS_REQ;
            end
            CS_LOAD:
            begin
                if (!gntn)
                begin
                    n.frameN  = 1'b0; // R6
                    n.frameOe = 1'b1;
                    n.busOe   = 1'b1;
                    n.ad      = r.addr;
                    n.cben    = r.cmd;
                    n.status  = BLW_STATUS_BUS_XACT;
                    n.remain  = r.len; // R7
                    n.irdyN   = 1'b1;
                    n.irdyOe  = 1'b1;
                    n.st      = CS_ADDR;
                end
                else
                begin
                    n.status = BLW_STATUS_IDLE;
                    n.st     = CS_REQ;
                end
            end
            CS_ADDR:
            begin
                {n.ad, n.cben} = curNextD; // R11
                n.st           = CS_WAIT1;
            end
            CS_WAIT1, CS_DATA:
            begin
                if (done)
                    n.remain = r.remain - 1'b1; // R18
                if (done && (r.remain == 1))
                begin
                    n.frameN  = 1'b1; // R21
                    n.frameOe = 1'b0;
                    n.busOe   = 1'b0;
                    n.irdyN   = 1'b1;
                    n.status  = BLW_STATUS_BUS_TERM;
                    n.ending  = BLW_END_NORMAL;
                    n.st      = CS_TURN;
                end
                else
                begin
                    {n.ad, n.cben} = curNextD; // R14
                    n.irdyN        = !curNextV; // R16 R19
                    n.frameN       = r.frameN || (curNextV && (n.remain == 1)); // R20
                    n.st           = CS_DATA;
                end
            end
            CS_TURN:
            begin
                n.irdyOe = 1'b0;
                n.status = BLW_STATUS_IDLE;
                n.st     = CS_IDLE;
            end
            default:
                n.st = CS_IDLE;
        endcase
        if (!r.frameN && r.frameOe && lm.localRequest32N)
            n.reqN = 1'b1; // R10
        // next word strobe, only with room and words still owed
        n.xferN = !(!lm.localReadyN // R8 R15
                    && ((n.st == CS_ADDR) || (n.st == CS_WAIT1) || (n.st == CS_DATA))
                    && (n.taken < n.len)
                    && !(curNextV && aheadNextV));
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r        <= '0;
            r.st     <= CS_IDLE;
            r.reqN   <= 1'b1;
            r.grantN <= 1'b1;
            r.frameN <= 1'b1;
            r.irdyN  <= 1'b1;
            r.xferN  <= 1'b1;
            r.status <= BLW_STATUS_IDLE;
            r.ending <= BLW_END_NONE;
        end
        else
        begin
            r <= n;
        end
    end

    // outputs
    assign reqn                        = r.reqN;
    assign framenOut                   = r.frameN;
    assign framenOe                    = r.frameOe;
    assign irdynOut                    = r.irdyN;
    assign irdynOe                     = r.irdyOe;
    assign adOut                       = r.ad;
    assign cbenOut                     = r.cben;
    assign adCbenOe                    = r.busOe;
    assign lm.localGrantN              = r.grantN;
    assign lm.localMasterState         = r.status;
    assign lm.localDataTransferStrobeN = r.xferN;
    assign lm.remainingBeatsCount      = r.remain;
    assign lm.endingKind               = r.ending;
endmodule
`default_nettype wire

// ### hw/blw_local_master.sv
// local master end: issues one write burst per command
`timescale 1ns/1ps
`default_nettype none
module blw_local_master
    import blw_pkg::*;
#(
    parameter int LEN_W = BLW_LEN_W
)(
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    // local side
    blw_local_if.master                lm,
    // command
    input  wire logic                  cmdValid,
    output logic                       cmdReady,
    input  wire logic [BLW_ADDR_W-1:0] cmdAddr,
    input  wire logic [BLW_BE_W-1:0]   cmdCode,
    input  wire logic [LEN_W-1:0]      cmdBurstLen,
    // write words
    input  wire logic                  wordValid,
    output logic                       wordReady,
    input  wire logic [BLW_DATA_W-1:0] wordData,
    input  wire logic [BLW_BE_W-1:0]   wordByteEn,
    // status
    output logic [BLW_ADDR_W-1:0]      wordAddr,
    output logic                       burstDone,
    output logic [1:0]                 burstEnding
);
    typedef struct packed {
        blw_host_e             st;
        logic                  reqN;
        logic [BLW_ADDR_W-1:0] addr;
        logic [BLW_BE_W-1:0]   cmd;
        logic [LEN_W-1:0]      len;
        logic [LEN_W-1:0]      left;
        logic [BLW_ADDR_W-1:0] nextAddr;
        logic                  holdV;
        logic [BLW_DATA_W-1:0] holdD;
        logic [BLW_BE_W-1:0]   holdBe;
        logic                  done;
        logic [1:0]            ending;
    } blw_host_s;

    blw_host_s r;
    blw_host_s n;
    logic      consume;

    always_comb
    begin
        n         = r;
        n.done    = 1'b0;
        consume   = r.holdV && !lm.localDataTransferStrobeN; // R8
        cmdReady  = (r.st == HS_IDLE);
        wordReady = (r.st != HS_IDLE) && (r.left != 0) && (!r.holdV || consume);
        if (consume)
        begin
            n.holdV    = 1'b0;
            n.nextAddr = r.nextAddr + BLW_ADDR_STEP; // R11
        end
        if (wordReady && wordValid)
        begin
            n.holdV  = 1'b1;
            n.holdD  = wordData;
            n.holdBe = wordByteEn;
            n.left   = r.left - 1'b1;
        end
        case (r.st)
            HS_IDLE:
            begin
                if (cmdValid)
                begin
                    n.reqN     = 1'b0; // R1
                    n.addr     = cmdAddr;
                    n.cmd      = cmdCode;
                    n.len      = cmdBurstLen;
                    n.left     = cmdBurstLen;
                    n.nextAddr = cmdAddr;
                    n.st       = HS_REQ;
                end
            end
            HS_REQ:
            begin
                if (lm.localMasterState == BLW_STATUS_ADDR_LOAD)
                begin
                    n.reqN = 1'b1; // R5
                    n.st   = HS_RUN;
                end
            end
            HS_RUN:
            begin
                if (lm.localMasterState == BLW_STATUS_BUS_TERM)
                begin
                    n.done   = 1'b1;
                    n.ending = lm.endingKind;
                    n.holdV  = 1'b0;
                    n.st     = HS_IDLE;
                end
            end
            default:
            begin
                n.st = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r      <= '0;
            r.st   <= HS_IDLE;
            r.reqN <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end

    // request fields while requesting, held word afterwards
    assign lm.localRequest32N  = r.reqN;
    assign lm.localAddrDataIn  = (r.st == HS_REQ) ? r.addr : r.holdD;
    assign lm.localCmdByteEnIn = (r.st == HS_REQ) ? r.cmd : r.holdBe;
    assign lm.localBurstLenIn  = r.len;
    assign lm.localReadyN      = !n.holdV; // R9 R22
    assign wordAddr            = r.nextAddr;
    assign burstDone           = r.done;
    assign burstEnding         = r.ending;
endmodule
`default_nettype wire

// ### sim/blw_monitor.sv
// concurrent checks on the local and bus sides of the write sequencer
`timescale 1ns/1ps
`default_nettype none
module blw_monitor
    import blw_pkg::*;
#(
    parameter int LEN_W = BLW_LEN_W
)(
    // clock and reset
    input wire logic                  sys_clk,
    input wire logic                  resetn,
    // local side
    input wire logic                  localRequest32N,
    input wire logic [BLW_DATA_W-1:0] localAddrDataIn,
    input wire logic [BLW_BE_W-1:0]   localCmdByteEnIn,
    input wire logic [LEN_W-1:0]      localBurstLenIn,
    input wire logic                  localReadyN,
    input wire logic                  localGrantN,
    input wire logic [3:0]            localMasterState,
    input wire logic                  localDataTransferStrobeN,
    input wire logic [LEN_W-1:0]      remainingBeatsCount,
    input wire logic [1:0]            endingKind,
    // bus side
    input wire logic                  reqn,
    input wire logic                  gntn,
    input wire logic                  framenIn,
    input wire logic                  irdynIn,
    input wire logic                  trdyn,
    input wire logic                  framenOut,
    input wire logic                  framenOe,
    input wire logic                  irdynOut,
    input wire logic                  irdynOe,
    input wire logic [BLW_DATA_W-1:0] adOut,
    input wire logic [BLW_BE_W-1:0]   cbenOut,
    input wire logic                  adCbenOe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    req_follow_a: assert property (
        $fell(localRequest32N) |=> !reqn) else $error("bus request not raised");
    grant_local_a: assert property (
        (!gntn && !reqn && framenIn && irdynIn && localMasterState == BLW_STATUS_IDLE)
        |=> !localGrantN) else $error("local grant missing");
    addr_load_a: assert property (
        (!localRequest32N && !localGrantN && !gntn && localMasterState == BLW_STATUS_IDLE)
        |=> localMasterState == BLW_STATUS_ADDR_LOAD) else $error("no address loading");
    frame_start_a: assert property (
        (localMasterState == BLW_STATUS_ADDR_LOAD && !gntn)
        |=> (!framenOut && framenOe && adCbenOe && localMasterState == BLW_STATUS_BUS_XACT
        && adOut == $past(localAddrDataIn) && cbenOut == $past(localCmdByteEnIn)))
        else $error("address phase wrong");
    beat_load_a: assert property (
        (localMasterState == BLW_STATUS_ADDR_LOAD && !gntn)
        |=> remainingBeatsCount == $past(localBurstLenIn)) else $error("burst count not loaded");
    strobe_cause_a: assert property (
        !localDataTransferStrobeN |-> !$past(localReadyN)) else $error("strobe without ready");
    reqn_drop_a: assert property (
        (framenOe && !framenOut && localRequest32N) |=> reqn) else $error("bus request held");
    grant_follow_a: assert property (
        gntn |=> localGrantN) else $error("local grant outlived bus grant");
    data_hold_a: assert property (
        (irdynOe && !irdynOut && trdyn) |=> (!irdynOut && $stable(adOut)
        && $stable(cbenOut) && $stable(framenOut))) else $error("data phase not held");
    beat_dec_a: assert property (
        (irdynOe && !irdynOut && !trdyn)
        |=> remainingBeatsCount == $past(remainingBeatsCount) - 1'b1)
        else $error("burst count not decremented");
    last_frame_a: assert property (
        ($rose(framenOut) && framenOe) |-> (irdynOe && !irdynOut && remainingBeatsCount == 1))
        else $error("final phase framing wrong");
    end_release_a: assert property (
        (framenOe && framenOut && irdynOe && !irdynOut && !trdyn)
        |=> (!framenOe && !adCbenOe && irdynOe && irdynOut
        && localMasterState == BLW_STATUS_BUS_TERM && endingKind == BLW_END_NORMAL)
        ##1 (!irdynOe && localMasterState == BLW_STATUS_IDLE)) else $error("bus not released");
endmodule
`default_nettype wire

// ### sim/pci_master_write_local_wait_tb.sv
// self-checking bench: local master and write sequencer joined end to end
`timescale 1ns/1ps
`default_nettype none
module pci_master_write_local_wait_tb
    import blw_pkg::*;
    ;
    logic        sys_clk, resetn, cmdValid, cmdReady, wordValid, wordReady, burstDone;
    logic [31:0] cmdAddr, wordData, wordAddr, adOut, obsAddr;
    logic [3:0]  cmdCode, wordByteEn, cbenOut, obsCmd;
    logic [7:0]  cmdBurstLen;
    logic [1:0]  burstEnding;
    logic        reqn, gntn, trdyn, framenOut, framenOe, irdynOut, irdynOe, adCbenOe;
    logic        framenIn, irdynIn, framenPrev, tgtBusy;
    logic [35:0] obsQ[$];
    int          error_cnt, cmp_count, tgtDly, tgtDelay;

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // pulled-up bus lines
    assign framenIn = framenOe ? framenOut : 1'b1;
    assign irdynIn  = irdynOe ? irdynOut : 1'b1;

    blw_local_if #(.LEN_W(BLW_LEN_W)) lmIf ();

    blw_core #(.LEN_W(BLW_LEN_W)) u_blw_core (.sys_clk(sys_clk), .resetn(resetn), .lm(lmIf),
        .reqn(reqn), .gntn(gntn), .framenIn(framenIn), .irdynIn(irdynIn), .trdyn(trdyn),
        .framenOut(framenOut), .framenOe(framenOe), .irdynOut(irdynOut), .irdynOe(irdynOe),
        .adOut(adOut), .cbenOut(cbenOut), .adCbenOe(adCbenOe));

    blw_local_master #(.LEN_W(BLW_LEN_W)) u_blw_local_master (.sys_clk(sys_clk),
        .resetn(resetn), .lm(lmIf), .cmdValid(cmdValid), .cmdReady(cmdReady),
        .cmdAddr(cmdAddr), .cmdCode(cmdCode), .cmdBurstLen(cmdBurstLen),
        .wordValid(wordValid), .wordReady(wordReady), .wordData(wordData),
        .wordByteEn(wordByteEn), .wordAddr(wordAddr), .burstDone(burstDone),
        .burstEnding(burstEnding));

    blw_monitor #(.LEN_W(BLW_LEN_W)) u_blw_monitor (.sys_clk(sys_clk), .resetn(resetn),
        .localRequest32N(lmIf.localRequest32N), .localAddrDataIn(lmIf.localAddrDataIn),
        .localCmdByteEnIn(lmIf.localCmdByteEnIn), .localBurstLenIn(lmIf.localBurstLenIn),
        .localReadyN(lmIf.localReadyN), .localGrantN(lmIf.localGrantN),
        .localMasterState(lmIf.localMasterState),
        .localDataTransferStrobeN(lmIf.localDataTransferStrobeN),
        .remainingBeatsCount(lmIf.remainingBeatsCount), .endingKind(lmIf.endingKind),
        .reqn(reqn), .gntn(gntn), .framenIn(framenIn), .irdynIn(irdynIn), .trdyn(trdyn),
        .framenOut(framenOut), .framenOe(framenOe), .irdynOut(irdynOut), .irdynOe(irdynOe),
        .adOut(adOut), .cbenOut(cbenOut), .adCbenOe(adCbenOe));

    // arbiter
    always @(posedge sys_clk or negedge resetn)
        if (!resetn)
            gntn <= 1'b1;
        else
            gntn <= reqn;

    // target
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            trdyn   <= 1'b1;
            tgtBusy <= 1'b0;
            tgtDly  <= 0;
        end
        else if (!tgtBusy)
        begin
            tgtBusy <= !framenIn;
            tgtDly  <= tgtDelay;
        end
        else
        begin
            if (tgtDly != 0)
                tgtDly <= tgtDly - 1;
            else
                trdyn <= 1'b0;
            if (!trdyn && !irdynIn && framenIn)
            begin
                trdyn   <= 1'b1;
                tgtBusy <= 1'b0;
            end
        end
    end

    // bus observer
    always @(posedge sys_clk)
        if (resetn)
        begin
            if (!framenIn && framenPrev)
            begin
                obsAddr = adOut;
                obsCmd  = cbenOut;
            end
            if (!irdynIn && !trdyn)
                obsQ.push_back({cbenOut, adOut});
            framenPrev = framenIn;
        end

    task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic give_up(input string name);
        error_cnt++;
        $display("CHECK FAILED %s expected handshake seen timeout", name);
        print_verdict();
    endtask

    task automatic send_cmd(input logic [31:0] a, input logic [3:0] c, input logic [7:0] l);
        int n;
        n = 0;
        cmdValid    <= 1'b1;
        cmdAddr     <= a;
        cmdCode     <= c;
        cmdBurstLen <= l;
        do begin @(posedge sys_clk); n++; end while (cmdReady !== 1'b1 && n < 100);
        if (n >= 100)
            give_up("command");
        cmdValid <= 1'b0;
    endtask

    // word strobe left up between words
    task automatic send_word(input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        wordValid  <= 1'b1;
        wordData   <= d;
        wordByteEn <= be;
        do begin @(posedge sys_clk); n++; end while (wordReady !== 1'b1 && n < 1000);
        if (n >= 1000)
            give_up("word");
    endtask

    task automatic run_burst(input logic [31:0] a, input logic [3:0] c, input int len,
                             input int gap, input int tdel);
        int n;
        tgtDelay = tdel;
        obsQ.delete();
        fork
            send_cmd(a, c, 8'(len));
            for (int i = 0; i < len; i++)
            begin
                send_word({a[15:0], 16'(i)}, c ^ 4'(i));
                if (gap > 0 && i == 1)
                begin
                    wordValid <= 1'b0;
                    repeat (gap) @(posedge sys_clk);
                end
            end
        join
        wordValid <= 1'b0;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (burstDone !== 1'b1 && n < 3000);
        if (n >= 3000)
            give_up("burst done");
        repeat (3) @(posedge sys_clk);
        check("ending", 36'(burstEnding), 36'(BLW_END_NORMAL));
        check("beats left", 36'(lmIf.remainingBeatsCount), '0);
        check("state", 36'(lmIf.localMasterState), 36'(BLW_STATUS_IDLE));
        check("bus address", 36'(obsAddr), 36'(a));
        check("bus command", 36'(obsCmd), 36'(c));
        check("word address", 36'(wordAddr), 36'(a + BLW_ADDR_STEP * 32'(len)));
        check("phases", 36'(obsQ.size()), 36'(len));
        for (int k = 0; k < len; k++)
            check("bus word", obsQ[k], {c ^ 4'(k), a[15:0], 16'(k)});
    endtask

    initial
    begin
        error_cnt   = 0;
        cmp_count   = 0;
        tgtDelay    = 0;
        framenPrev  = 1'b1;
        resetn      = 1'b0;
        cmdValid    = 1'b0;
        cmdAddr     = '0;
        cmdCode     = '0;
        cmdBurstLen = '0;
        wordValid   = 1'b0;
        wordData    = '0;
        wordByteEn  = '0;
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        run_burst(32'h1000_0000, 4'h7, 3, 0, 0);
        run_burst(32'h2000_0040, 4'h7, 3, 3, 0);
        run_burst(32'h3000_0100, 4'hF, 1, 0, 2);
        run_burst(32'h4000_0000, 4'h7, 8, 1, 1);
        run_burst(32'h5000_0000, 4'hF, 255, 0, 0);
        print_verdict();
    end
endmodule
`default_nettype wire
